/* File: design/tps_pkg.sv */
// package: register map, field positions, reset values and timing for the 8-bit timer
package tps_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_TIMER_COUNT       = 8'h01;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_OPTION_CONFIG     = 8'h81;
  localparam logic [7:0] IDX_CORE_CONTROL      = 8'h90;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_CLOCK_SOURCE_SELECT = 5;
  localparam int BIT_SOURCE_EDGE_SELECT  = 4;
  localparam int BIT_PRESCALER_ASSIGN    = 3;
  localparam int BIT_OVERFLOW_INT_ENABLE = 5;
  localparam int BIT_OVERFLOW_FLAG       = 2;
  localparam int BIT_SLEEP               = 0;
  localparam int BIT_WATCHDOG_CLEAR      = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OPTION_CONFIG = 8'hFF;
  localparam logic [7:0] RST_TIMER_COUNT   = 8'h00;
  localparam logic [7:0] RST_PRESCALER     = 8'h00;

  // ----------------------------------------------------------------
  // timing: clock periods per instruction cycle, write inhibit length
  // ----------------------------------------------------------------
  localparam logic [1:0] INSN_DIV_LAST   = 2'h3;
  localparam logic [1:0] WRITE_INHIBIT   = 2'h2;

  // option register fields carried together
  typedef struct packed {
    logic       pin_pullup_off;
    logic       int_edge;
    logic       clock_source_select;
    logic       source_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio_field;
  } tps_option_t;

  typedef enum logic {TPS_BUS_IDLE, TPS_BUS_ACK} tps_bus_state_t;

endpackage

/* File: design/tps_timer.sv */
// 8-bit timer/counter with shared prescaler behind an Avalon-MM slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps

module tps_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // external count pin
  input  wire logic        external_count_pin,
  // watchdog side
  input  wire logic        wdt_base_tick,
  output logic             wdt_post_tick,
  output logic             wdt_clear,
  // processor side
  output logic             overflow_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tps_pkg::tps_bus_state_t bus_state;
  tps_pkg::tps_option_t    option_config;
  logic [7:0]              timer_count;
  logic [7:0]              prescaler;
  logic                    overflow_flag;
  logic                    overflow_int_enable;
  logic                    sleep_mode;
  logic [1:0]              insn_div;
  logic                    insn_tick;
  logic [1:0]              inhibit_cnt;
  logic                    pin_sync1;
  logic                    pin_sync2;
  logic                    pin_last;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0] reg_index;
  logic       word_ok;
  logic       wr_go;
  logic       wr_timer;
  logic       wr_intctl;
  logic       wr_option;
  logic       wr_core;
  logic       wdt_clear_req;

  assign reg_index = avs_address[9:2];
  assign word_ok   = (avs_address[1:0] == 2'h0) && avs_byteenable[0];
  // a write takes effect only at the edge where waitrequest is seen low
  assign wr_go     = (bus_state == tps_pkg::TPS_BUS_ACK) && avs_write && word_ok;
  assign wr_timer  = wr_go && (reg_index == tps_pkg::IDX_TIMER_COUNT);
  assign wr_intctl = wr_go && (reg_index == tps_pkg::IDX_INTERRUPT_CONTROL);
  assign wr_option = wr_go && (reg_index == tps_pkg::IDX_OPTION_CONFIG);
  assign wr_core   = wr_go && (reg_index == tps_pkg::IDX_CORE_CONTROL);
  assign wdt_clear_req = wr_core && avs_writedata[tps_pkg::BIT_WATCHDOG_CLEAR];

  // ----------------------------------------------------------------
  // bus slave: one wait state, then a single-cycle answer
  // ----------------------------------------------------------------
  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    case (reg_index)
      tps_pkg::IDX_TIMER_COUNT: begin
        read_mux = timer_count;
      end
      tps_pkg::IDX_INTERRUPT_CONTROL: begin
        read_mux[tps_pkg::BIT_OVERFLOW_INT_ENABLE] = overflow_int_enable;
        read_mux[tps_pkg::BIT_OVERFLOW_FLAG]       = overflow_flag;
      end
      tps_pkg::IDX_OPTION_CONFIG: begin
        read_mux = option_config;
      end
      tps_pkg::IDX_CORE_CONTROL: begin
        read_mux[tps_pkg::BIT_SLEEP] = sleep_mode;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
    // the prescaler has no address: it can never be read or written
    if (avs_address[1:0] != 2'h0) begin
      read_mux = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_state       <= tps_pkg::TPS_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        tps_pkg::TPS_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state       <= tps_pkg::TPS_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h00_0000, read_mux};
          end
        end
        tps_pkg::TPS_BUS_ACK: begin
          bus_state       <= tps_pkg::TPS_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= tps_pkg::TPS_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      option_config <= tps_pkg::RST_OPTION_CONFIG;
    end else if (wr_option) begin
      // assignment may be switched while counting runs
      option_config <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_mode <= 1'b0;
    end else if (wr_core) begin
      sleep_mode <= avs_writedata[tps_pkg::BIT_SLEEP];
    end
  end

  // ----------------------------------------------------------------
  // instruction cycle: four clocks each
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      insn_div  <= 2'h0;
      insn_tick <= 1'b0;
    end else begin
      insn_div  <= (insn_div == tps_pkg::INSN_DIV_LAST) ? 2'h0 : insn_div + 2'h1;
      insn_tick <= (insn_div == tps_pkg::INSN_DIV_LAST);
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser and edge pick
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_last  <= 1'b0;
    end else begin
      pin_sync1 <= external_count_pin;
      pin_sync2 <= pin_sync1;
      pin_last  <= pin_sync2;
    end
  end

  logic pin_edge;
  logic src_event;

  // edge detection reads only the second stage and later, never the first
  assign pin_edge  = option_config.source_edge_select ? (pin_last && !pin_sync2)
                                                      : (!pin_last && pin_sync2);
  assign src_event = option_config.clock_source_select ? pin_edge : insn_tick;

  // ----------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------
  logic [7:0] mask_tmr;
  logic [7:0] mask_wdt;
  logic       pre_to_tmr;
  logic       pre_step;
  logic       tmr_pre_done;
  logic       wdt_pre_done;

  // ratio field n: timer divides by 2^(n+1), watchdog by 2^n
  assign mask_tmr = 8'((9'h002 << option_config.prescale_ratio_field) - 9'h001);
  assign mask_wdt = 8'((9'h001 << option_config.prescale_ratio_field) - 9'h001);
  assign pre_to_tmr = !option_config.prescaler_assign;
  // sleep freezes the timer side of the prescaler as well
  assign pre_step = pre_to_tmr ? (src_event && !sleep_mode) : wdt_base_tick;
  assign tmr_pre_done = (prescaler & mask_tmr) == mask_tmr;
  assign wdt_pre_done = (prescaler & mask_wdt) == mask_wdt;

  always_ff @(posedge clk) begin
    if (reset) begin
      prescaler <= tps_pkg::RST_PRESCALER;
    end else if (wr_timer && pre_to_tmr) begin
      prescaler <= tps_pkg::RST_PRESCALER;
    end else if (wdt_clear_req && !pre_to_tmr) begin
      prescaler <= tps_pkg::RST_PRESCALER;
    end else if (pre_step) begin
      prescaler <= prescaler + 8'h01;
    end
  end

  // watchdog sees its base tick directly when the timer owns the prescaler
  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_post_tick <= 1'b0;
    end else begin
      wdt_post_tick <= wdt_base_tick && (pre_to_tmr || wdt_pre_done);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= wdt_clear_req;
    end
  end

  // ----------------------------------------------------------------
  // counter and write inhibit
  // ----------------------------------------------------------------
  logic inc_timer;

  // the inhibit runs out on instruction cycles, not clocks, so a write blocks
  // counting for the same two instruction cycles in either mode
  assign inc_timer = src_event && !sleep_mode && (inhibit_cnt == 2'h0) &&
                     (!pre_to_tmr || tmr_pre_done);

  always_ff @(posedge clk) begin
    if (reset) begin
      inhibit_cnt <= 2'h0;
    end else if (wr_timer) begin
      inhibit_cnt <= tps_pkg::WRITE_INHIBIT;
    end else if (insn_tick && (inhibit_cnt != 2'h0)) begin
      inhibit_cnt <= inhibit_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_count <= tps_pkg::RST_TIMER_COUNT;
    end else if (wr_timer) begin
      timer_count <= avs_writedata[7:0];
    end else if (inc_timer) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and request
  // ----------------------------------------------------------------
  logic wrap_now;

  assign wrap_now = inc_timer && !wr_timer && (timer_count == 8'hFF);

  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag       <= 1'b0;
      overflow_int_enable <= 1'b0;
    end else begin
      if (wr_intctl) begin
        overflow_int_enable <= avs_writedata[tps_pkg::BIT_OVERFLOW_INT_ENABLE];
      end
      // a wrap in the clearing cycle wins; only software clears it
      if (wrap_now) begin
        overflow_flag <= 1'b1;
      end else if (wr_intctl) begin
        overflow_flag <= avs_writedata[tps_pkg::BIT_OVERFLOW_FLAG];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && overflow_int_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_wrap_sets_flag;
    @(posedge clk) disable iff (reset)
      wrap_now |=> (timer_count == 8'h00) && overflow_flag;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("wrap did not set flag");

  property p_inhibit_loaded;
    @(posedge clk) disable iff (reset)
      wr_timer |=> (inhibit_cnt == 2'h2) ##1 (inhibit_cnt != 2'h0);
  endproperty
  a_inhibit_loaded: assert property (p_inhibit_loaded) else $error("inhibit not armed");

  property p_inhibit_holds;
    @(posedge clk) disable iff (reset)
      (inhibit_cnt != 2'h0) && !wr_timer |=> $stable(timer_count);
  endproperty
  a_inhibit_holds: assert property (p_inhibit_holds) else $error("count moved in inhibit");

  property p_sleep_holds;
    @(posedge clk) disable iff (reset)
      sleep_mode && !wr_timer |=> $stable(timer_count);
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("count moved in sleep");

  property p_write_clears_pre;
    @(posedge clk) disable iff (reset)
      wr_timer && pre_to_tmr |=> (prescaler == 8'h00);
  endproperty
  a_write_clears_pre: assert property (p_write_clears_pre) else $error("prescaler kept");

  property p_wdt_clear;
    @(posedge clk) disable iff (reset)
      wdt_clear_req && !pre_to_tmr |=> (prescaler == 8'h00) && wdt_clear;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear missed");

  property p_irq_gate;
    @(posedge clk) disable iff (reset)
      ##1 (overflow_irq == ($past(overflow_flag) && $past(overflow_int_enable)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request not gated");

  property p_flag_sticky;
    @(posedge clk) disable iff (reset)
      overflow_flag && !wr_intctl |=> overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

  property p_timer_rate;
    @(posedge clk) disable iff (reset)
      insn_tick && !option_config.clock_source_select && !pre_to_tmr && !sleep_mode &&
      (inhibit_cnt == 2'h0) && !wr_timer |=> (timer_count == $past(timer_count) + 8'h01);
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer mode missed a cycle");

  property p_pin_to_count;
    @(posedge clk) disable iff (reset)
      option_config.clock_source_select && !pre_to_tmr && !sleep_mode && !wr_timer &&
      (inhibit_cnt == 2'h0) && pin_edge |=> (timer_count == $past(timer_count) + 8'h01);
  endproperty
  a_pin_to_count: assert property (p_pin_to_count) else $error("pin edge not counted");

  property p_bus_answer;
    @(posedge clk) disable iff (reset)
      (bus_state == tps_pkg::TPS_BUS_IDLE) && (avs_read || avs_write) |=>
        !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_wrap:     cover property (@(posedge clk) disable iff (reset) wrap_now);
  c_irq:      cover property (@(posedge clk) disable iff (reset) overflow_irq);
  c_fall_cnt: cover property (@(posedge clk) disable iff (reset)
                option_config.source_edge_select && pin_edge && inc_timer);
  c_wdt_post: cover property (@(posedge clk) disable iff (reset)
                wdt_post_tick && !pre_to_tmr);

endmodule

/* File: sim/tps_wdt_model.sv */
// partner model: watchdog timebase, pulse counters and external count pin driver
`timescale 1ns/100ps

module tps_wdt_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // watchdog side
  output logic      wdt_base_tick,
  input  wire logic wdt_post_tick,
  input  wire logic wdt_clear,
  // count pin
  output logic      external_count_pin
);
  logic [1:0] div;
  int         post_seen;
  int         clear_seen;

  initial external_count_pin = 1'b0;

  // ----------------------------------------------------------------
  // timebase: one tick every four clocks, steady so window counts are exact
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    div <= reset ? 2'h0 : div + 2'h1;
    wdt_base_tick <= !reset && (div == 2'h3);
  end

  // non-blocking counts: a bench read at the same edge always sees the pre-edge total
  always_ff @(posedge clk) begin
    if (wdt_post_tick === 1'b1) post_seen <= post_seen + 1;
    if (wdt_clear === 1'b1) clear_seen <= clear_seen + 1;
  end

  // ----------------------------------------------------------------
  // pin level changes right after an edge
  // ----------------------------------------------------------------
  task automatic set_pin(input logic v);
    @(posedge clk);
    external_count_pin <= v;
  endtask
endmodule

/* File: sim/test_eight_bit_timer_with_shared_prescaler.sv */
// self-checking bench for the 8-bit timer with shared prescaler
`timescale 1ns/100ps

module test_eight_bit_timer_with_shared_prescaler;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        external_count_pin, wdt_base_tick, wdt_post_tick, wdt_clear, overflow_irq;
  logic [7:0]  a, b, c, v, junk;
  int          fail_count, checks, p0, c0;

  tps_timer DUT (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_pin(external_count_pin), .wdt_base_tick(wdt_base_tick),
    .wdt_post_tick(wdt_post_tick), .wdt_clear(wdt_clear), .overflow_irq(overflow_irq));

  tps_wdt_model model (.clk(clk), .reset(reset), .wdt_base_tick(wdt_base_tick),
    .wdt_post_tick(wdt_post_tick), .wdt_clear(wdt_clear),
    .external_count_pin(external_count_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // verdict, comparison and bus tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low; only the 60000-clock bench timeout ends a dead wait
  task automatic bus(input logic [9:0] adr, input logic wr, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    @(posedge clk);
    avs_address    <= adr;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus({idx, 2'b00}, 1'b1, d, 4'hF, junk);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    bus({idx, 2'b00}, 1'b0, 8'h00, 4'hF, q);
  endtask

  // two reads whose sampling edges lie exactly t clocks apart
  task automatic rate(input int t, output logic [7:0] d);
    rd(tps_pkg::IDX_TIMER_COUNT, a);
    repeat (t - 3) @(posedge clk);
    rd(tps_pkg::IDX_TIMER_COUNT, b);
    d = b - a;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32));
    reset = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(tps_pkg::IDX_OPTION_CONFIG, a);
    chk("option reset", 8'hFF, a);
    rd(tps_pkg::IDX_TIMER_COUNT, a);
    chk("count reset", 8'h00, a);
    rd(tps_pkg::IDX_INTERRUPT_CONTROL, a);
    chk("intctl reset", 8'h00, a);
    wr(8'h55, 8'hA5);
    rd(8'h55, a);
    chk("unmapped", 8'h00, a);
    bus(10'h205, 1'b0, 8'h00, 4'hF, a);
    chk("misaligned", 8'h00, a);
    // sleep freezes counting so random write/readback is exact
    wr(tps_pkg::IDX_CORE_CONTROL, 8'h01);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(tps_pkg::IDX_TIMER_COUNT, v);
      bus({tps_pkg::IDX_TIMER_COUNT, 2'b00}, 1'b1, ~v, 4'h0, junk);
      repeat (20) @(posedge clk);
      rd(tps_pkg::IDX_TIMER_COUNT, a);
      chk("count readback", v, a);
    end
    rate(40, c);
    chk("sleep frozen", 8'h00, c);
    wr(tps_pkg::IDX_CORE_CONTROL, 8'h00);
    wr(tps_pkg::IDX_OPTION_CONFIG, 8'h08);
    rate(400, c);
    chk("timer rate", 8'd100, c);
    v = 8'($urandom);
    wr(tps_pkg::IDX_TIMER_COUNT, v);
    repeat (39) @(posedge clk);
    rd(tps_pkg::IDX_TIMER_COUNT, a);
    // 40 clocks hold ten instruction cycles; the first two after the write are lost
    chk("write inhibit", 8'd8, a - v);
    // overflow flag and masking
    wr(tps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    wr(tps_pkg::IDX_TIMER_COUNT, 8'hF0);
    repeat (100) @(posedge clk);
    rd(tps_pkg::IDX_INTERRUPT_CONTROL, a);
    chk("flag set", 8'h04, a);
    chk("irq masked", 8'h00, {7'h00, overflow_irq});
    wr(tps_pkg::IDX_INTERRUPT_CONTROL, 8'h24);
    repeat (3) @(posedge clk);
    chk("irq enabled", 8'h01, {7'h00, overflow_irq});
    repeat (400) @(posedge clk);
    rd(tps_pkg::IDX_INTERRUPT_CONTROL, a);
    chk("flag kept", 8'h24, a);
    wr(tps_pkg::IDX_INTERRUPT_CONTROL, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, overflow_irq});
    // timer-owned prescaler: every ratio
    for (int n = 0; n < 8; n++) begin
      wr(tps_pkg::IDX_OPTION_CONFIG, {5'h00, 3'(n)});
      repeat (8 << n) @(posedge clk);
      rate(16 << n, c);
      chk("timer prescale", 8'd2, c);
    end
    // a count write restarts the 1:256 prescaler from zero
    repeat ($urandom_range(0, 1000)) @(posedge clk);
    v = 8'($urandom);
    wr(tps_pkg::IDX_TIMER_COUNT, v);
    repeat (600) @(posedge clk);
    rd(tps_pkg::IDX_TIMER_COUNT, a);
    chk("prescaler zeroed", v, a);
    // counter mode, both edges
    for (int e = 0; e < 2; e++) begin
      wr(tps_pkg::IDX_OPTION_CONFIG, 8'h28 | (8'(e) << 4));
      model.set_pin(1'b0);
      repeat (8) @(posedge clk);
      rd(tps_pkg::IDX_TIMER_COUNT, a);
      model.set_pin(1'b1);
      repeat (8) @(posedge clk);
      rd(tps_pkg::IDX_TIMER_COUNT, b);
      chk("rising edge", 8'(e == 0), b - a);
      model.set_pin(1'b0);
      repeat (8) @(posedge clk);
      rd(tps_pkg::IDX_TIMER_COUNT, c);
      chk("falling edge", 8'(e == 1), c - b);
      for (int k = 0; k < 5; k++) begin
        model.set_pin(1'b1);
        repeat (6) @(posedge clk);
        model.set_pin(1'b0);
        repeat (6) @(posedge clk);
      end
      rd(tps_pkg::IDX_TIMER_COUNT, a);
      chk("pin count", 8'd5, a - c);
    end
    // watchdog-owned prescaler: clear first, then move it
    for (int n = 0; n < 8; n++) begin
      wr(tps_pkg::IDX_CORE_CONTROL, 8'h02);
      wr(tps_pkg::IDX_OPTION_CONFIG, 8'h08 | 8'(n));
      repeat (8 << n) @(posedge clk);
      p0 = model.post_seen;
      repeat (32 << n) @(posedge clk);
      chk("wdt postscale", 8'd8, 8'(model.post_seen - p0));
    end
    repeat ($urandom_range(0, 400)) @(posedge clk);
    c0 = model.clear_seen;
    wr(tps_pkg::IDX_CORE_CONTROL, 8'h02);
    repeat (2) @(posedge clk);
    p0 = model.post_seen;
    repeat (400) @(posedge clk);
    chk("wdt clear pulse", 8'd1, 8'(model.clear_seen - c0));
    chk("postscaler zeroed", 8'd0, 8'(model.post_seen - p0));
    wr(tps_pkg::IDX_OPTION_CONFIG, 8'h00);
    repeat (8) @(posedge clk);
    p0 = model.post_seen;
    repeat (80) @(posedge clk);
    chk("wdt unscaled", 8'd20, 8'(model.post_seen - p0));
    final_report();
  end
endmodule
